// [pio_map.svh]
`ifndef PIO_MAP_SVH
`define PIO_MAP_SVH

// ------------------------------------------------------------
// Register byte offsets, one aligned 32-bit word each
// ------------------------------------------------------------
`define ONE_DATA_OFS     6'h00
`define ONE_DIR_OFS      6'h04
`define THREE_DATA_OFS   6'h08
`define THREE_DIR_OFS    6'h0C
`define FOUR_DATA_OFS    6'h10
`define FOUR_DIR_OFS     6'h14
`define PULLUP_OFS       6'h18
`define DRIVE_OFS        6'h1C
`define KEY_EN_OFS       6'h20
`define CONV_CTRL_OFS    6'h24
`define CMP_CTRL_OFS     6'h28
`define TIMER_Z_OFS      6'h2C

// ------------------------------------------------------------
// Implemented bits and field positions
// ------------------------------------------------------------
`define ONE_MASK         8'hFF
`define THREE_MASK       8'hB8
`define FOUR_MASK        8'h20
`define LOW_PINS_MASK    8'h0F
`define PULLUP_BIT       2
`define TZ_CTL_BIT       2

// ------------------------------------------------------------
// Converter channel codes for the four low pins
// ------------------------------------------------------------
`define CH_PIN0          4'h9
`define CH_PIN1          4'hB
`define CH_PIN2          4'hD
`define CH_PIN3          4'hF

// ------------------------------------------------------------
// Timer Z mode codes and reset values
// ------------------------------------------------------------
`define TZ_MODE_PORT     2'h0
`define TZ_MODE_PULSE    2'h1
`define RST_BYTE         8'h00
`define RST_CH           4'h0

`endif

// [pio_pkg.sv]
package pio_pkg;

   // Avalon-MM request from the master
   typedef struct packed {
      logic        read;
      logic        write;
      logic [5:0]  address;
      logic [31:0] writedata;
   } avs_req_t;

   // Pin vector: [7:0] port one, [11:8] port three 3,4,5,7,
   // [12] port four 5
   typedef logic [12:0] pin_vec_t;

   // Whole state of the port block
   typedef struct packed {
      pin_vec_t    sync1;
      pin_vec_t    sync2;
      logic [7:0]  one_lat;
      logic [7:0]  one_dir;
      logic [7:0]  three_lat;
      logic [7:0]  three_dir;
      logic [7:0]  four_lat;
      logic [7:0]  four_dir;
      logic [7:0]  pullup_control_zero;
      logic [3:0]  drive_strength_reg;
      logic [3:0]  key_input_enable_reg;
      logic [3:0]  converter_group_select;
      logic [2:0]  compare_output_control;
      logic [1:0]  timer_z_mode;
      logic        timer_z_output_control;
      logic        waitrequest;
      logic [31:0] readdata;
      pin_vec_t    pin_out;
      pin_vec_t    pin_oe;
      logic [3:0]  high_drive;
      pin_vec_t    pullup_en;
      logic [3:0]  key_level;
      logic [3:0]  analog_route;
   } pio_state_t;

endpackage

// [pio_port.sv]
// Summary of operation
// R1 - Every implemented pin has a direction bit: 0 input, 1 output.
// R2 - Port data holds an output latch plus a separate pin sampling path.
// R3 - Data read returns pin level when direction 0, latch when 1.
// R4 - Data writes always update the latch, even in input mode.
// R5 - Direction 1 drives the latch value onto the pin.
// R6 - Missing port four direction bits read 0; software writes 0.
// R7 - Port three data bits 0-2 and 6 read 0; software writes 0.
// R8 - Missing port three and four direction bits have no storage.
// R9 - Software sets direction 0 when a pin feeds a peripheral input.
// R10 - A peripheral output drives its shared pin whatever the direction.
// R11 - Shared pull-up bit connects pull-ups on port one pins 0-3 inputs.
// R12 - Per-pin drive bit selects high drive on plain outputs 0-3.
// R13 - Channel codes 1001b, 1011b route pins 0, 1 to the converter.
// R14 - Channel codes 1101b, 1111b route pins 2, 3 to the converter.
// R15 - Code 1011b selects pin 1 only while its direction is 0.
// R16 - Code 1101b selects pin 2 only while its direction is 0.
// R17 - Input pins 0-3 pass level to key logic when key enable is 1.
// R18 - Compare control and latch pick compare outputs; timer Z fields pin 3.
//
// Implementation choices: register access over Avalon-MM and the register addresses.
`timescale 1ns/1ps
`include "pio_map.svh"
`default_nettype none

module pio_port
#(
   parameter int CH_W = 4
)
(
   input  wire logic              sys_clk,
   input  wire logic              rst,
   input  wire pio_pkg::avs_req_t avs_req,
   output var  logic [31:0]       readdata,
   output var  logic              waitrequest,
   input  wire pio_pkg::pin_vec_t pin_in,
   output var  pio_pkg::pin_vec_t pin_out,
   output var  pio_pkg::pin_vec_t pin_oe,
   output var  pio_pkg::pin_vec_t pullup_en,
   output var  logic [3:0]        high_drive,
   input  wire logic [2:0]        compare_out_zero,
   input  wire logic              timer_z_output_pin,
   output var  logic [3:0]        key_level,
   output var  logic [3:0]        analog_route
);
   import pio_pkg::*;

   // ------------------------------------------------------------
   // Elaboration check
   // ------------------------------------------------------------
   // The channel codes are four bits wide; other widths cannot decode
   if (CH_W != 4)
   begin : g_bad_width
      $error("CH_W must be 4");
   end

   pio_state_t st;
   pio_state_t next_st;

   // ------------------------------------------------------------
   // Decoding helpers
   // ------------------------------------------------------------
   // Per-bit read mux: pin level in input mode, latch in output mode
   function automatic logic [7:0] port_read(input logic [7:0] dir,
                                            input logic [7:0] lat,
                                            input logic [7:0] lvl,
                                            input logic [7:0] mask);
      port_read = ((dir & lat) | (~dir & lvl)) & mask; // R3
   endfunction

   // Word read of a byte register, upper bits zero
   function automatic logic [31:0] byte_word(input logic [7:0] b);
      byte_word = {24'h000000, b};
   endfunction

   // Port-wide views of the synchronised pin levels
   logic [7:0] one_lvl;
   logic [7:0] three_lvl;
   logic [7:0] four_lvl;
   assign one_lvl   = st.sync2[7:0];
   assign three_lvl = {st.sync2[11], 1'b0, st.sync2[10:8], 3'b000};
   assign four_lvl  = {2'b00, st.sync2[12], 5'b00000};

   // Peripheral take-over of the four low pins
   logic [3:0] periph_act;
   logic [3:0] periph_val;
   logic [3:0] forced_port;
   logic       tz_act;
   logic       tz_forced;
   always_comb
   begin
      tz_act = (st.timer_z_mode == `TZ_MODE_PULSE
                && !st.timer_z_output_control)
               || st.timer_z_mode[1];                       // R18
      tz_forced = (st.timer_z_mode == `TZ_MODE_PULSE)
                  && st.timer_z_output_control;             // R18
      for (int i = 0; i < 3; i++)
      begin
         periph_act[i]  = st.compare_output_control[i]
                          && st.one_lat[i];                  // R18
         forced_port[i] = st.compare_output_control[i]
                          && !st.one_lat[i];                 // R18
         periph_val[i]  = compare_out_zero[i];
      end
      periph_act[3]  = tz_act;
      forced_port[3] = tz_forced;
      periph_val[3]  = timer_z_output_pin;
   end

   // ------------------------------------------------------------
   // Next-state logic
   // ------------------------------------------------------------
   logic        req;
   logic        wr_go;
   logic [7:0]  wb;
   pin_vec_t    dir_all;
   pin_vec_t    lat_all;
   logic [CH_W-1:0] ch;
   logic [CH_W-1:0] codes [4];
   assign req     = avs_req.read || avs_req.write;
   assign wr_go   = avs_req.write && !st.waitrequest;
   assign wb      = avs_req.writedata[7:0];
   assign dir_all = {st.four_dir[5], st.three_dir[7], st.three_dir[5:3],
                     st.one_dir};
   assign lat_all = {st.four_lat[5], st.three_lat[7], st.three_lat[5:3],
                     st.one_lat};
   assign ch      = st.converter_group_select;
   assign codes   = '{`CH_PIN0, `CH_PIN1, `CH_PIN2, `CH_PIN3};

   always_comb
   begin
      next_st = st;
      // Two-stage synchroniser on the raw pins
      next_st.sync1 = pin_in;
      next_st.sync2 = st.sync1;                              // R2

      // One wait cycle per access, then one cycle of acknowledge
      next_st.waitrequest = !(req && st.waitrequest);
      if (avs_req.read && st.waitrequest)
      begin
         unique case (avs_req.address)
            `ONE_DATA_OFS:   next_st.readdata = byte_word(port_read(
                   st.one_dir, st.one_lat, one_lvl, `ONE_MASK));
            `THREE_DATA_OFS: next_st.readdata = byte_word(port_read(
                   st.three_dir, st.three_lat, three_lvl,
                   `THREE_MASK));                             // R7
            `FOUR_DATA_OFS:  next_st.readdata = byte_word(port_read(
                   st.four_dir, st.four_lat, four_lvl, `FOUR_MASK));
            `ONE_DIR_OFS:    next_st.readdata = byte_word(st.one_dir);
            `THREE_DIR_OFS:  next_st.readdata = byte_word(st.three_dir);
            `FOUR_DIR_OFS:   next_st.readdata = byte_word(st.four_dir);
            `PULLUP_OFS:
               next_st.readdata = byte_word(st.pullup_control_zero);
            `DRIVE_OFS:
               next_st.readdata = {28'h0000000, st.drive_strength_reg};
            `KEY_EN_OFS:
               next_st.readdata = {28'h0000000, st.key_input_enable_reg};
            `CONV_CTRL_OFS:
               next_st.readdata = {28'h0000000, ch};
            `CMP_CTRL_OFS:
               next_st.readdata = {29'h00000000,
                                   st.compare_output_control};
            `TIMER_Z_OFS:
               next_st.readdata = {29'h00000000,
                                   st.timer_z_output_control,
                                   st.timer_z_mode};
            default:         next_st.readdata = 32'h00000000;
         endcase
      end

      // Writes land at the acknowledge edge; missing bits store nothing
      if (wr_go)
      begin
         unique case (avs_req.address)
            `ONE_DATA_OFS:   next_st.one_lat   = wb & `ONE_MASK;   // R4
            `THREE_DATA_OFS: next_st.three_lat = wb & `THREE_MASK; // R4
            `FOUR_DATA_OFS:  next_st.four_lat  = wb & `FOUR_MASK;  // R4
            `ONE_DIR_OFS:    next_st.one_dir   = wb & `ONE_MASK;   // R1
            `THREE_DIR_OFS:  next_st.three_dir = wb & `THREE_MASK; // R8
            `FOUR_DIR_OFS:   next_st.four_dir  = wb & `FOUR_MASK;  // R6
            `PULLUP_OFS:     next_st.pullup_control_zero = wb;
            `DRIVE_OFS:      next_st.drive_strength_reg = wb[3:0];
            `KEY_EN_OFS:     next_st.key_input_enable_reg = wb[3:0];
            `CONV_CTRL_OFS:  next_st.converter_group_select = wb[3:0];
            `CMP_CTRL_OFS:   next_st.compare_output_control = wb[2:0];
            `TIMER_Z_OFS:
            begin
               next_st.timer_z_mode           = wb[1:0];
               next_st.timer_z_output_control = wb[`TZ_CTL_BIT];
            end
            default:         next_st.readdata = st.readdata;
         endcase
      end

      // Pin drive: peripherals win, forced port outputs next, then
      // the direction bit; the pull-up only serves undriven pins
      for (int i = 0; i < 13; i++)
      begin
         next_st.pin_out[i] = lat_all[i];
         next_st.pin_oe[i]  = dir_all[i];                     // R5
         next_st.pullup_en[i] = 1'b0;
      end
      for (int i = 0; i < 4; i++)
      begin
         if (periph_act[i])
         begin
            next_st.pin_out[i] = periph_val[i];               // R10
            next_st.pin_oe[i]  = 1'b1;                        // R10
         end
         else if (forced_port[i])
         begin
            next_st.pin_oe[i] = 1'b1;                         // R18
         end
         next_st.pullup_en[i] = !next_st.pin_oe[i]
            && st.pullup_control_zero[`PULLUP_BIT];           // R11
         next_st.high_drive[i] = next_st.pin_oe[i] && !periph_act[i]
            && st.drive_strength_reg[i];                      // R12
         next_st.key_level[i] = !next_st.pin_oe[i]
            && st.key_input_enable_reg[i] && st.sync2[i];     // R17
         next_st.analog_route[i] = !next_st.pin_oe[i]        // R15 R16
            && !st.pullup_control_zero[`PULLUP_BIT]
            && (ch == codes[i]);                              // R13 R14
      end
   end

   // ------------------------------------------------------------
   // State register
   // ------------------------------------------------------------
   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         st <= '0;
         st.waitrequest <= 1'b1;
         st.converter_group_select <= `RST_CH;
         st.pullup_control_zero <= `RST_BYTE;
      end
      else
      begin
         st <= next_st;
      end
   end

   // Every output straight from the state flops
   assign readdata     = st.readdata;
   assign waitrequest  = st.waitrequest;
   assign pin_out      = st.pin_out;
   assign pin_oe       = st.pin_oe;
   assign pullup_en    = st.pullup_en;
   assign high_drive   = st.high_drive;
   assign key_level    = st.key_level;
   assign analog_route = st.analog_route;

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (rst);

   sequence access_taken;
      req && waitrequest;
   endsequence
   sequence ack_then_idle;
      !waitrequest ##1 waitrequest;
   endsequence

   bus_ack_a: assert property (access_taken |=> ack_then_idle) // Avalon-MM handshake
      else $error("access not acknowledged after one wait cycle");

   latch_write_a: assert property (                            // R4
      avs_req.write && !waitrequest && avs_req.address == `ONE_DATA_OFS
      |=> st.one_lat == $past(avs_req.writedata[7:0]))
      else $error("port one latch missed a write");

   read_mux_a: assert property (                               // R3
      avs_req.read && waitrequest && avs_req.address == `ONE_DATA_OFS
      |=> readdata[7:0] == (($past(st.one_dir) & $past(st.one_lat))
          | (~$past(st.one_dir) & $past(st.sync2[7:0]))))
      else $error("port one read mux wrong");

   three_zero_a: assert property (                             // R7
      avs_req.read && waitrequest && avs_req.address == `THREE_DATA_OFS
      |=> (readdata[7:0] & ~`THREE_MASK) == 8'h00)
      else $error("unimplemented port three bits read nonzero");

   four_dir_a: assert property (                               // R6
      (st.four_dir & ~`FOUR_MASK) == 8'h00
      && (st.three_dir & ~`THREE_MASK) == 8'h00)              // R8
      else $error("unimplemented direction bits hold storage");

   out_drive_a: assert property (                              // R5
      st.one_dir[7] |=> pin_oe[7] && pin_out[7] == $past(st.one_lat[7]))
      else $error("output mode pin not driven from latch");

   input_float_a: assert property (                            // R1
      !st.one_dir[6] |=> !pin_oe[6])
      else $error("input mode pin driven");

   cmp_override_a: assert property (                           // R10
      st.compare_output_control[0] && st.one_lat[0]
      |=> pin_oe[0] && pin_out[0] == $past(compare_out_zero[0])
          && !high_drive[0])
      else $error("compare output not on pin 0");

   pullup_a: assert property (                                 // R11
      !next_st.pin_oe[1] && st.pullup_control_zero[`PULLUP_BIT]
      |=> pullup_en[1])
      else $error("pull-up not connected on input pin");

   drive_a: assert property (                                  // R12
      st.one_dir[2] && !st.compare_output_control[2]
      |=> high_drive[2] == $past(st.drive_strength_reg[2]))
      else $error("drive strength not applied");

   analog_dir_a: assert property (                             // R15
      st.converter_group_select == `CH_PIN1 && !st.one_dir[1]
      && !st.pullup_control_zero[`PULLUP_BIT]
      && !st.compare_output_control[1] |=> analog_route[1])
      else $error("pin 1 not routed to converter");

   analog_out_a: assert property (                             // R16
      st.one_dir[2] |=> !analog_route[2])
      else $error("output pin 2 routed to converter");

   key_pass_a: assert property (                               // R17
      !next_st.pin_oe[0] && st.key_input_enable_reg[0]
      |=> key_level[0] == $past(st.sync2[0]))
      else $error("key input not passed from pin 0");

   analog_excl_a: assert property (                            // R14
      analog_route[3] |-> !pin_oe[3])
      else $error("analog pin also driven");

   timer_z_a: assert property (                                // R18
      st.timer_z_mode[1] |=> pin_oe[3]
      && pin_out[3] == $past(timer_z_output_pin))
      else $error("timer Z output not on pin 3");

   // Mode 01 with output control set keeps pin 3 a plain port output
   tz_forced_a: assert property (                              // R18
      st.timer_z_mode == `TZ_MODE_PULSE && st.timer_z_output_control
      |=> pin_oe[3] && pin_out[3] == $past(st.one_lat[3]))
      else $error("forced port output not on pin 3");

endmodule

`default_nettype wire

// [pin_partner.sv]
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// Pin wires outside the port block
// ------------------------------------------------------------
module pin_partner
(
   input  wire logic              sys_clk,
   input  wire pio_pkg::pin_vec_t pin_out,
   input  wire pio_pkg::pin_vec_t pin_oe,
   input  wire pio_pkg::pin_vec_t pullup_en,
   input  wire pio_pkg::pin_vec_t ext_drive,
   input  wire pio_pkg::pin_vec_t ext_level,
   output var  pio_pkg::pin_vec_t pin_in
);
   import pio_pkg::*;
   logic flip = 1'b0;

   // Undriven lines wander, so a stale level never reads back
   always_ff @(posedge sys_clk)
      flip <= ~flip;

   // Block drive wins, then outside driver, then pull-up
   always_comb
   begin
      for (int i = 0; i < 13; i++)
      begin
         if (pin_oe[i])
            pin_in[i] = pin_out[i];
         else if (ext_drive[i])
            pin_in[i] = ext_level[i];
         else if (pullup_en[i])
            pin_in[i] = 1'b1;
         else
            pin_in[i] = flip ^ i[0];
      end
   end
endmodule
`default_nettype wire

// [test_programmable_io_port_pin_select.sv]
`timescale 1ns/1ps
`include "pio_map.svh"
`default_nettype none
module test_programmable_io_port_pin_select;
   import pio_pkg::*;
   typedef struct {logic [5:0] ofs; logic [31:0] wr; logic [31:0] rd;} row_t;
   logic        sys_clk = 1'b0;
   logic        rst = 1'b1;
   avs_req_t    avs_req = '0;
   logic [31:0] readdata, rdv;
   logic        waitrequest;
   pin_vec_t    pin_in, pin_out, pin_oe, pullup_en;
   pin_vec_t    ext_drive = '0;
   pin_vec_t    ext_level = '0;
   logic [3:0]  high_drive, key_level, analog_route;
   logic [2:0]  compare_out_zero = 3'h0;
   logic        timer_z_output_pin = 1'b0;
   int          n_fail = 0;
   int          tests_run = 0;
   int          cycles = 0;
   // Write value, then the readback that the implemented bits give
   row_t rows [9] = '{
      '{`ONE_DIR_OFS,   32'hFF, 32'hFF},
      '{`THREE_DIR_OFS, 32'hFF, 32'hB8},
      '{`FOUR_DIR_OFS,  32'hFF, 32'h20},
      '{`DRIVE_OFS,     32'hFF, 32'h0F},
      '{`KEY_EN_OFS,    32'hFF, 32'h0F},
      '{`CONV_CTRL_OFS, 32'hFF, 32'h0F},
      '{`CMP_CTRL_OFS,  32'hFF, 32'h07},
      '{`TIMER_Z_OFS,   32'hFF, 32'h07},
      '{6'h30,          32'hFF, 32'h00}};

   pio_port #(.CH_W(4)) i_dut (
      .sys_clk            (sys_clk),
      .rst                (rst),
      .avs_req            (avs_req),
      .readdata           (readdata),
      .waitrequest        (waitrequest),
      .pin_in             (pin_in),
      .pin_out            (pin_out),
      .pin_oe             (pin_oe),
      .pullup_en          (pullup_en),
      .high_drive         (high_drive),
      .compare_out_zero   (compare_out_zero),
      .timer_z_output_pin (timer_z_output_pin),
      .key_level          (key_level),
      .analog_route       (analog_route));

   pin_partner i_pins (
      .sys_clk   (sys_clk),
      .pin_out   (pin_out),
      .pin_oe    (pin_oe),
      .pullup_en (pullup_en),
      .ext_drive (ext_drive),
      .ext_level (ext_level),
      .pin_in    (pin_in));

   // ------------------------------------------------------------
   // Clock, watchdog and closing report
   // ------------------------------------------------------------
   initial
   begin
      forever #25 sys_clk = ~sys_clk;
   end

   task automatic end_of_test();
      $display("Checks run %0d, mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   // A hung handshake ends the run as a mismatch
   always @(posedge sys_clk)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         n_fail++;
         end_of_test();
      end
   end

   // ------------------------------------------------------------
   // Bus cycles and comparison
   // ------------------------------------------------------------
   task automatic chk(input string what, input logic [31:0] exp,
                      input logic [31:0] got);
      tests_run++;
      if (got !== exp)
      begin
         n_fail++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask

   // Request held until waitrequest is sampled low at a rising edge;
   // read data is taken and the request dropped at that same edge
   task automatic bus(input logic rd, input logic [5:0] a,
                      input logic [31:0] d);
      @(posedge sys_clk);
      avs_req <= '{read: rd, write: ~rd, address: a, writedata: d};
      do
         @(posedge sys_clk);
      while (waitrequest !== 1'b0);
      rdv = readdata;
      avs_req <= '0;
   endtask

   task automatic wr(input logic [5:0] a, input logic [31:0] d);
      bus(1'b0, a, d);
   endtask

   task automatic rd_chk(input string what, input logic [5:0] a,
                         input logic [31:0] exp);
      bus(1'b1, a, 32'h0);
      chk(what, exp, rdv);
   endtask

   // Two sync flops plus the output register, with margin
   task automatic settle();
      repeat (3) @(posedge sys_clk);
      @(negedge sys_clk);
   endtask

   task automatic set_ext(input pin_vec_t drv, input pin_vec_t lvl,
                          input logic [2:0] cmp, input logic tz);
      @(posedge sys_clk);
      ext_drive <= drv;
      ext_level <= lvl;
      compare_out_zero <= cmp;
      timer_z_output_pin <= tz;
   endtask

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial
   begin
      repeat (7) @(posedge sys_clk);
      @(negedge sys_clk);
      chk("wait in reset", 32'h1, 32'(waitrequest));
      chk("oe in reset", 32'h0, 32'(pin_oe));
      @(posedge sys_clk);
      rst <= 1'b0;
      rd_chk("dir reset", `ONE_DIR_OFS, 32'h0);
      // Register masks, then back to zero
      for (int i = 0; i < 9; i++)
      begin
         wr(rows[i].ofs, rows[i].wr);
         rd_chk("readback", rows[i].ofs, rows[i].rd);
         wr(rows[i].ofs, 32'h0);
      end
      // Input read, latch kept while in input mode, then driven
      set_ext(13'h0FF, 13'h03C, 3'h0, 1'b0);
      wr(`ONE_DATA_OFS, 32'hA5);
      rd_chk("input level", `ONE_DATA_OFS, 32'h3C);
      wr(`ONE_DIR_OFS, 32'hF0);
      settle();
      chk("oe", 32'h0F0, 32'(pin_oe));
      chk("drive", 32'h0A0, 32'(pin_out & pin_oe));
      rd_chk("mixed read", `ONE_DATA_OFS, 32'hAC);
      wr(`THREE_DIR_OFS, 32'hFF);
      wr(`THREE_DATA_OFS, 32'hFF);
      rd_chk("port three", `THREE_DATA_OFS, 32'hB8);
      wr(`FOUR_DATA_OFS, 32'hFF);
      wr(`FOUR_DIR_OFS, 32'hFF);
      rd_chk("port four", `FOUR_DATA_OFS, 32'h20);
      settle();
      chk("oe wide", 32'h1FF0, 32'(pin_oe));
      wr(`ONE_DIR_OFS, 32'h0);
      wr(`THREE_DIR_OFS, 32'h0);
      wr(`FOUR_DIR_OFS, 32'h0);
      // Pull-up and drive strength on the four low pins
      set_ext(13'h0, 13'h0, 3'h0, 1'b0);
      wr(`PULLUP_OFS, 32'h1 << `PULLUP_BIT);
      settle();
      chk("pullup", 32'hF, 32'(pullup_en));
      wr(`ONE_DIR_OFS, 32'h01);
      settle();
      chk("pullup out", 32'hE, 32'(pullup_en));
      wr(`ONE_DIR_OFS, 32'h0F);
      wr(`DRIVE_OFS, 32'h5);
      settle();
      chk("high drive", 32'h5, 32'(high_drive));
      wr(`ONE_DIR_OFS, 32'h0);
      wr(`CONV_CTRL_OFS, 32'h9);
      settle();
      chk("high drive in", 32'h0, 32'(high_drive));
      chk("route pulled", 32'h0, 32'(analog_route));
      wr(`PULLUP_OFS, 32'h0);
      // Every channel code, then blocked by direction
      for (int i = 0; i < 4; i++)
      begin
         wr(`CONV_CTRL_OFS, 32'h9 + 32'(2 * i));
         settle();
         chk("route", 32'h1 << i, 32'(analog_route));
      end
      wr(`CONV_CTRL_OFS, 32'hB);
      wr(`ONE_DIR_OFS, 32'h2);
      settle();
      chk("route dir1", 32'h0, 32'(analog_route));
      wr(`CONV_CTRL_OFS, 32'hD);
      wr(`ONE_DIR_OFS, 32'h4);
      settle();
      chk("route dir2", 32'h0, 32'(analog_route));
      wr(`CONV_CTRL_OFS, 32'h0);
      // Key inputs follow input pins only
      set_ext(13'h00F, 13'h00A, 3'h0, 1'b0);
      wr(`ONE_DIR_OFS, 32'h0);
      wr(`KEY_EN_OFS, 32'hF);
      settle();
      chk("key level", 32'hA, 32'(key_level));
      wr(`ONE_DIR_OFS, 32'h2);
      settle();
      chk("key driven", 32'h8, 32'(key_level));
      wr(`ONE_DIR_OFS, 32'h0);
      // Compare outputs with latch 0101, direction left at input
      set_ext(13'h0, 13'h0, 3'b101, 1'b1);
      wr(`ONE_DATA_OFS, 32'h05);
      wr(`CMP_CTRL_OFS, 32'h7);
      settle();
      chk("cmp oe", 32'h7, 32'(pin_oe[2:0]));
      chk("cmp out", 32'h5, 32'(pin_out[2:0]));
      set_ext(13'h0, 13'h0, 3'b010, 1'b1);
      settle();
      chk("cmp out low", 32'h0, 32'(pin_out[2:0]));
      // Timer output modes on pin 3
      wr(`TIMER_Z_OFS, 32'h1);
      settle();
      chk("tz pin", 32'h3, 32'({pin_oe[3], pin_out[3]}));
      set_ext(13'h0, 13'h0, 3'b010, 1'b0);
      settle();
      chk("tz pin low", 32'h2, 32'({pin_oe[3], pin_out[3]}));
      wr(`TIMER_Z_OFS, 32'h5);
      set_ext(13'h0, 13'h0, 3'b010, 1'b1);
      settle();
      chk("tz forced", 32'h2, 32'({pin_oe[3], pin_out[3]}));
      wr(`TIMER_Z_OFS, 32'h2);
      settle();
      chk("tz mode 2", 32'h3, 32'({pin_oe[3], pin_out[3]}));
      // Reset in mid-run must drop every drive and control again
      @(posedge sys_clk);
      rst <= 1'b1;
      repeat (2) @(posedge sys_clk);
      @(negedge sys_clk);
      chk("oe after reset", 32'h0, 32'(pin_oe));
      chk("wait after reset", 32'h1, 32'(waitrequest));
      @(posedge sys_clk);
      rst <= 1'b0;
      rd_chk("tz after reset", `TIMER_Z_OFS, 32'h0);
      rd_chk("cmp after reset", `CMP_CTRL_OFS, 32'h0);
      end_of_test();
   end
endmodule
`default_nettype wire
